/* File: hdl/serial_node_pkg.sv */
// Purpose: Shared constants and types for the serial node front end
// Assumes: 20 MHz core clock
// Notes:   Bit periods derive from the 38400 bps period by powers of two
package serial_node_pkg;
  // Clock and timing
  localparam int CLK_HZ           = 20_000_000;
  localparam int BAUD_FASTEST     = 38400;
  localparam int BIT_CYCLES_FAST  = CLK_HZ / BAUD_FASTEST;
  localparam int TENTH_SEC_MS     = 100;
  localparam int TENTH_CYCLES     = (CLK_HZ / 1000) * TENTH_SEC_MS;
  localparam logic [5:0] GAP_BITS = 6'h26;  // About 3.5 characters of idle line

  // Timeout action codes
  localparam logic [1:0] ACT_RAMP1 = 2'h0;
  localparam logic [1:0] ACT_COAST = 2'h1;
  localparam logic [1:0] ACT_RAMP2 = 2'h2;
  localparam logic [1:0] ACT_RUN   = 2'h3;
  // Bit rate codes
  localparam logic [1:0] RATE_4800  = 2'h0;
  localparam logic [1:0] RATE_9600  = 2'h1;
  localparam logic [1:0] RATE_19200 = 2'h2;
  localparam logic [1:0] RATE_38400 = 2'h3;
  // Stop, parity and width codes
  localparam logic       STOP_TWO  = 1'b1;
  localparam logic [1:0] PAR_NONE  = 2'h0;
  localparam logic [1:0] PAR_EVEN  = 2'h1;
  localparam logic [1:0] PAR_ODD   = 2'h2;
  localparam logic       WIDTH_7   = 1'b1;
  // Node addressing
  localparam logic [7:0] NODE_BCAST = 8'h00;
  localparam logic [7:0] NODE_MIN   = 8'h01;
  localparam logic [7:0] NODE_MAX   = 8'hFE;
  // Reset values
  localparam logic [7:0] RST_NODE   = 8'h01;
  localparam logic [1:0] RST_RATE   = RATE_9600;
  localparam logic [1:0] RST_ACTION = ACT_RAMP1;
  localparam logic [7:0] RST_DETECT = 8'h00;

  typedef struct packed {
    logic [7:0] node_number;
    logic [1:0] bit_rate_select;
    logic       stop_bit_select;
    logic [1:0] parity_select;
    logic       char_width_select;
  } fmt_t;

  typedef struct packed {
    logic [1:0] timeout_action_select;
    logic [7:0] timeout_detect_time;
  } sup_t;

  typedef struct packed {
    logic ramp_first_decel;
    logic coast;
    logic ramp_second_decel;
  } stop_t;

  typedef struct packed {
    logic timeout;
    logic busy;
    logic refused;
    logic char_error;
  } status_t;

  // Gray codes along idle, start, data, parity, stop
  typedef enum logic [2:0] {
    IDLE_S  = 3'b000,
    START_S = 3'b001,
    DATA_S  = 3'b011,
    PAR_S   = 3'b010,
    STOP_S  = 3'b110
  } line_state_t;
endpackage

/* File: hdl/serial_node_comm_timeout.sv */
// Purpose: Serial character engine, node filter and link time-out supervisor
// Assumes: rxd and all control inputs synchronous to clk
// Notes:   Frames end on an idle gap; upper layers check the frame body
// Summary of operation
// R1 - On time-out apply action: ramp decel one, coast, ramp decel two, keep running
// R2 - Time-out declared when no good frame within 0 to 25.5 s window
// R3 - Latched time-out cleared by reset key or by a received frame
// R4 - Clearing a stopping time-out does not restart; a fresh run command needed
// R5 - Action and detection time changes refused while communication is busy
// R6 - Detection time enables supervision; run and frequency path left alone
// R7 - Node number 1 to 254 held; only frames to that node accepted; the code also accepts address zero frames (R13)
// R8 - Bit rate codes select 4800, 9600, 19200 or 38400 bps
// R9 - Stop setting selects one or two stop bits
// R10 - Parity none, even or odd on both transmit and receive
// R11 - Data width code selects eight or seven data bits
// R12 - Master addresses at most 32 nodes, each with a distinct number
// R13 - Address zero frames accepted by every node
// R14 - Master uses the same rate, stop, parity and width as the node
// R15 - Node number and format writes from the link are refused
// R16 - Zero detection time disables; otherwise each good frame restarts the timer
// R17 - Frames with parity or framing errors dropped and do not restart timer
module serial_node_comm_timeout
  import serial_node_pkg::*;
#(
  parameter logic [12:0] BIT_BASE   = 13'(BIT_CYCLES_FAST),
  parameter logic [20:0] TENTH_CNT  = 21'(TENTH_CYCLES)
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   rxd,
  output logic                        txd,
  output logic                        tx_drive_en,
  input  wire logic                   tx_valid,
  input  wire logic [7:0]             tx_data,
  output logic                        tx_ready,
  output logic [7:0]                  rx_data,
  output logic                        rx_valid,
  output logic                        frame_good,
  output logic                        frame_bad,
  input  wire logic                   cfg_wr_fmt,
  input  wire logic                   cfg_wr_sup,
  input  wire logic                   cfg_from_link,
  input  wire serial_node_pkg::fmt_t  cfg_fmt,
  input  wire serial_node_pkg::sup_t  cfg_sup,
  output serial_node_pkg::fmt_t       fmt,
  output serial_node_pkg::sup_t       sup,
  input  wire logic                   reset_key,
  input  wire logic                   run_cmd,
  output logic                        drive_run,
  output serial_node_pkg::stop_t      stop_act,
  output serial_node_pkg::status_t    status
);
  import serial_node_pkg::*;

  // Bit period in clocks for a rate code
  function automatic logic [12:0] bit_period(input logic [1:0] rate);
    unique case (rate)
      RATE_4800:  return BIT_BASE << 3;
      RATE_9600:  return BIT_BASE << 2;
      RATE_19200: return BIT_BASE << 1;
      default:    return BIT_BASE;
    endcase
  endfunction

  // Parity bit over the active data bits
  function automatic logic par_bit(input logic [7:0] d, input logic w7, input logic [1:0] ps);
    logic p;
    p = ^(w7 ? {1'b0, d[6:0]} : d);
    return (ps == PAR_ODD) ? ~p : p;
  endfunction

  line_state_t rx_state, next_rx_state, tx_state, next_tx_state;
  logic [12:0] rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt, period;
  logic [2:0]  rx_bitn, next_rx_bitn, tx_bitn, next_tx_bitn, last_bit;
  logic [7:0]  rx_sh, next_rx_sh, tx_sh, next_tx_sh;
  logic        rx_perr, next_rx_perr, rx_ferr, next_rx_ferr;
  logic        rx_stopn, next_rx_stopn, tx_stopn, next_tx_stopn;
  logic        rx_done, next_rx_done, use_par, busy;
  logic        next_txd, next_tx_ready, next_tx_drive_en;
  logic        in_frame, next_in_frame, addr_ok, next_addr_ok, f_err, next_f_err;
  logic [5:0]  gap, next_gap;
  logic [7:0]  next_rx_data;
  logic        next_rx_valid, next_frame_good, next_frame_bad;
  fmt_t        next_fmt;
  sup_t        next_sup;
  status_t     next_status;
  logic [20:0] tenth, next_tenth;
  logic [7:0]  elapsed, next_elapsed;
  logic        inhibit, next_inhibit, run_prev, sup_on, fire, clr, next_drive_run;
  logic [1:0]  stop_sel, next_stop_sel;
  stop_t       next_stop_act;

  // Character format in force; counters reload one below the bit period
  always_comb begin
    period   = bit_period(fmt.bit_rate_select) - 13'h0001;     // R8
    last_bit = (fmt.char_width_select == WIDTH_7) ? 3'h6 : 3'h7;  // R11
    use_par  = fmt.parity_select != PAR_NONE;                  // R10
    busy     = rx_state != IDLE_S || in_frame || tx_state != IDLE_S;
  end

  // Receiver: mid-bit sampling, parity and stop checks
  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt   = (rx_cnt != 13'h0000) ? rx_cnt - 13'h0001 : rx_cnt;
    next_rx_bitn  = rx_bitn;
    next_rx_sh    = rx_sh;
    next_rx_perr  = rx_perr;
    next_rx_ferr  = rx_ferr;
    next_rx_stopn = rx_stopn;
    next_rx_done  = 1'b0;
    unique case (rx_state)
      IDLE_S: begin
        if (!rxd) begin
          next_rx_cnt   = period >> 1;
          next_rx_state = START_S;
        end else if (rx_cnt == 13'h0000) begin
          next_rx_cnt = period;  // Free bit ticks for gap timing
        end
      end
      START_S: if (rx_cnt == 13'h0000) begin
        next_rx_state = rxd ? IDLE_S : DATA_S;
        next_rx_cnt   = period;
        next_rx_bitn  = 3'h0;
        next_rx_sh    = 8'h00;
        next_rx_perr  = 1'b0;
        next_rx_ferr  = 1'b0;
        next_rx_stopn = 1'b0;
      end
      DATA_S: if (rx_cnt == 13'h0000) begin
        next_rx_sh[rx_bitn] = rxd;
        next_rx_bitn        = rx_bitn + 3'h1;
        next_rx_cnt         = period;
        if (rx_bitn == last_bit) begin                          // R11
          next_rx_state = use_par ? PAR_S : STOP_S;
        end
      end
      PAR_S: if (rx_cnt == 13'h0000) begin
        next_rx_perr  = rxd != par_bit(rx_sh, fmt.char_width_select, fmt.parity_select);  // R10
        next_rx_cnt   = period;
        next_rx_state = STOP_S;
      end
      STOP_S: if (rx_cnt == 13'h0000) begin
        next_rx_ferr = rx_ferr | ~rxd;
        if (fmt.stop_bit_select == STOP_TWO && !rx_stopn) begin  // R9
          next_rx_stopn = 1'b1;
          next_rx_cnt   = period;
        end else begin
          next_rx_done  = 1'b1;
          next_rx_state = IDLE_S;
        end
      end
      default: next_rx_state = IDLE_S;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state <= IDLE_S;
      rx_cnt   <= 13'h0000;
      rx_bitn  <= 3'h0;
      rx_sh    <= 8'h00;
      rx_perr  <= 1'b0;
      rx_ferr  <= 1'b0;
      rx_stopn <= 1'b0;
      rx_done  <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_cnt   <= next_rx_cnt;
      rx_bitn  <= next_rx_bitn;
      rx_sh    <= next_rx_sh;
      rx_perr  <= next_rx_perr;
      rx_ferr  <= next_rx_ferr;
      rx_stopn <= next_rx_stopn;
      rx_done  <= next_rx_done;
    end
  end

  // Frame tracking: address filter, error collection, idle gap end
  always_comb begin
    next_in_frame   = in_frame;
    next_addr_ok    = addr_ok;
    next_f_err      = f_err;
    next_gap        = gap;
    next_rx_data    = rx_data;
    next_rx_valid   = 1'b0;
    next_frame_good = 1'b0;
    next_frame_bad  = 1'b0;
    if (rx_done) begin
      next_gap     = 6'h00;
      next_rx_data = rx_sh;
      if (!in_frame) begin
        next_in_frame = 1'b1;
        next_addr_ok  = rx_sh == fmt.node_number || rx_sh == NODE_BCAST;  // R7 R13
        next_f_err    = rx_perr | rx_ferr;
        next_rx_valid = rx_sh == fmt.node_number || rx_sh == NODE_BCAST;
      end else begin
        next_f_err    = f_err | rx_perr | rx_ferr;
        next_rx_valid = addr_ok;
      end
    end else if (rx_state != IDLE_S) begin
      next_gap = 6'h00;
    end else if (in_frame && rx_cnt == 13'h0000) begin
      next_gap = gap + 6'h01;
      if (gap == GAP_BITS - 6'h01) begin
        next_in_frame   = 1'b0;
        next_frame_good = addr_ok && !f_err;                    // R17
        next_frame_bad  = addr_ok && f_err;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_frame   <= 1'b0;
      addr_ok    <= 1'b0;
      f_err      <= 1'b0;
      gap        <= 6'h00;
      rx_data    <= 8'h00;
      rx_valid   <= 1'b0;
      frame_good <= 1'b0;
      frame_bad  <= 1'b0;
    end else begin
      in_frame   <= next_in_frame;
      addr_ok    <= next_addr_ok;
      f_err      <= next_f_err;
      gap        <= next_gap;
      rx_data    <= next_rx_data;
      rx_valid   <= next_rx_valid;
      frame_good <= next_frame_good;
      frame_bad  <= next_frame_bad;
    end
  end

  // Transmitter with line driver enable
  always_comb begin
    next_tx_state    = tx_state;
    next_tx_cnt      = (tx_cnt != 13'h0000) ? tx_cnt - 13'h0001 : tx_cnt;
    next_tx_bitn     = tx_bitn;
    next_tx_sh       = tx_sh;
    next_tx_stopn    = tx_stopn;
    next_txd         = txd;
    next_tx_ready    = tx_ready;
    next_tx_drive_en = tx_drive_en;
    unique case (tx_state)
      IDLE_S: if (tx_valid && tx_ready) begin
        next_tx_sh       = tx_data;
        next_tx_state    = START_S;
        next_tx_cnt      = period;
        next_txd         = 1'b0;
        next_tx_ready    = 1'b0;
        next_tx_drive_en = 1'b1;
      end
      START_S: if (tx_cnt == 13'h0000) begin
        next_tx_state = DATA_S;
        next_tx_bitn  = 3'h0;
        next_tx_cnt   = period;
        next_txd      = tx_sh[0];
      end
      DATA_S: if (tx_cnt == 13'h0000) begin
        next_tx_cnt  = period;
        next_tx_bitn = tx_bitn + 3'h1;
        if (tx_bitn == last_bit) begin                          // R11
          next_tx_state = use_par ? PAR_S : STOP_S;
          next_txd      = use_par ?
                          par_bit(tx_sh, fmt.char_width_select, fmt.parity_select) : 1'b1;  // R10
          next_tx_stopn = 1'b0;
        end else begin
          next_txd = tx_sh[tx_bitn + 3'h1];
        end
      end
      PAR_S: if (tx_cnt == 13'h0000) begin
        next_tx_state = STOP_S;
        next_tx_cnt   = period;
        next_txd      = 1'b1;
        next_tx_stopn = 1'b0;
      end
      STOP_S: if (tx_cnt == 13'h0000) begin
        if (fmt.stop_bit_select == STOP_TWO && !tx_stopn) begin  // R9
          next_tx_stopn = 1'b1;
          next_tx_cnt   = period;
        end else begin
          next_tx_state    = IDLE_S;
          next_tx_ready    = 1'b1;
          next_tx_drive_en = 1'b0;
        end
      end
      default: next_tx_state = IDLE_S;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state    <= IDLE_S;
      tx_cnt      <= 13'h0000;
      tx_bitn     <= 3'h0;
      tx_sh       <= 8'h00;
      tx_stopn    <= 1'b0;
      txd         <= 1'b1;
      tx_ready    <= 1'b1;
      tx_drive_en <= 1'b0;
    end else begin
      tx_state    <= next_tx_state;
      tx_cnt      <= next_tx_cnt;
      tx_bitn     <= next_tx_bitn;
      tx_sh       <= next_tx_sh;
      tx_stopn    <= next_tx_stopn;
      txd         <= next_txd;
      tx_ready    <= next_tx_ready;
      tx_drive_en <= next_tx_drive_en;
    end
  end

  // Settings: local format writes only, supervisor writes when idle
  always_comb begin
    next_fmt    = fmt;
    next_sup    = sup;
    next_status = '0;
    if (cfg_wr_fmt) begin
      if (cfg_from_link || busy || cfg_fmt.node_number < NODE_MIN ||   // R15
          cfg_fmt.node_number > NODE_MAX || cfg_fmt.parity_select > PAR_ODD) begin  // R7
        next_status.refused = 1'b1;
      end else begin
        next_fmt = cfg_fmt;
      end
    end
    if (cfg_wr_sup) begin
      if (busy) begin
        next_status.refused = 1'b1;                            // R5
      end else begin
        next_sup = cfg_sup;
      end
    end
    next_status.timeout    = fire | (status.timeout & ~clr);  // R3
    next_status.busy       = busy;
    next_status.char_error = rx_done & (rx_perr | rx_ferr);
  end

  // Time-out supervisor
  always_comb begin
    sup_on        = sup.timeout_detect_time != 8'h00;          // R6 R16
    clr           = reset_key | frame_good;                    // R3
    next_tenth    = tenth;
    next_elapsed  = elapsed;
    fire          = 1'b0;
    if (!sup_on || clr) begin                                  // R16
      next_tenth   = 21'h000000;
      next_elapsed = 8'h00;
    end else if (!status.timeout) begin
      next_tenth = tenth + 21'h000001;
      if (tenth == TENTH_CNT - 21'h000001) begin
        next_tenth   = 21'h000000;
        next_elapsed = elapsed + 8'h01;
        fire         = elapsed + 8'h01 == sup.timeout_detect_time;  // R2
      end
    end
    next_stop_sel = stop_sel;
    next_inhibit  = inhibit;
    if (fire && sup.timeout_action_select != ACT_RUN) begin    // R1
      next_inhibit  = 1'b1;
      next_stop_sel = sup.timeout_action_select;
    end else if (inhibit && !status.timeout && run_cmd && !run_prev) begin
      next_inhibit = 1'b0;                                     // R4
    end
    next_stop_act.ramp_first_decel  = next_inhibit && next_stop_sel == ACT_RAMP1;  // R1
    next_stop_act.coast             = next_inhibit && next_stop_sel == ACT_COAST;
    next_stop_act.ramp_second_decel = next_inhibit && next_stop_sel == ACT_RAMP2;
    next_drive_run                  = run_cmd && !next_inhibit;  // R4 R6
  end

  // Settings, supervisor state and status registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fmt       <= '{RST_NODE, RST_RATE, 1'b0, PAR_NONE, 1'b0};
      sup       <= '{RST_ACTION, RST_DETECT};
      status    <= '0;
      tenth     <= 21'h000000;
      elapsed   <= 8'h00;
      inhibit   <= 1'b0;
      stop_sel  <= RST_ACTION;
      run_prev  <= 1'b0;
      drive_run <= 1'b0;
      stop_act  <= '0;
    end else begin
      fmt       <= next_fmt;
      sup       <= next_sup;
      status    <= next_status;
      tenth     <= next_tenth;
      elapsed   <= next_elapsed;
      inhibit   <= next_inhibit;
      stop_sel  <= next_stop_sel;
      run_prev  <= run_cmd;
      drive_run <= next_drive_run;
      stop_act  <= next_stop_act;
    end
  end
endmodule // serial_node_comm_timeout

/* File: dv/link_master.sv */
// Purpose: Serial master model on the node's receive and transmit lines
// Assumes: Bench supplies the format in force; BIT cycles per bit at rate code 3
// Notes:   The line idles high as a biased bus does between characters
module link_master
  import serial_node_pkg::*;
#(
  parameter int BIT = 8
) (
  input  wire logic                  clk,
  input  wire logic                  txd,
  input  wire serial_node_pkg::fmt_t cfg,
  output logic                       rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int p;
  initial rxd = 1'b1;

  // One bit held for a full bit time
  task automatic emit(input logic b);
    rxd = b;
    repeat (p) @(negedge clk);
  endtask

  // One character in the node's own format, parity spoilt on request
  task automatic send(input logic [7:0] d, input logic bad);
    int n;
    n = cfg.char_width_select ? 7 : 8;
    p = BIT << (3 - cfg.bit_rate_select);
    emit(1'b0);
    for (int i = 0; i < n; i++) emit(d[i]);
    if (cfg.parity_select != PAR_NONE)
      emit((^(d & (n == 7 ? 8'h7F : 8'hFF))) ^ (cfg.parity_select == PAR_ODD) ^ bad);
    emit(1'b1);
    if (cfg.stop_bit_select) emit(1'b1);
  endtask

  // Samples a character from the node at mid bit
  task automatic grab(output logic [7:0] d, output logic pb);
    int n;
    n = cfg.char_width_select ? 7 : 8;
    p = BIT << (3 - cfg.bit_rate_select);
    d = 8'h00;
    pb = 1'b0;
    for (int t = 0; t < 5000 && txd; t++) @(negedge clk);
    repeat (p / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (p) @(negedge clk);
      d[i] = txd;
    end
    if (cfg.parity_select != PAR_NONE) begin
      repeat (p) @(negedge clk);
      pb = txd;
    end
  endtask
endmodule // link_master

/* File: dv/serial_node_sva.sv */
// Purpose: Port level checks of the serial node front end
// Assumes: Single clock domain, reset active high
// Notes:   Bound to every instance of the node
module serial_node_sva
  import serial_node_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     txd,
  input wire logic                     tx_drive_en,
  input wire logic                     tx_valid,
  input wire logic                     tx_ready,
  input wire logic                     frame_good,
  input wire logic                     frame_bad,
  input wire logic                     cfg_wr_fmt,
  input wire logic                     cfg_wr_sup,
  input wire logic                     cfg_from_link,
  input wire serial_node_pkg::sup_t    cfg_sup,
  input wire serial_node_pkg::fmt_t    fmt,
  input wire serial_node_pkg::sup_t    sup,
  input wire logic                     drive_run,
  input wire serial_node_pkg::stop_t   stop_act,
  input wire serial_node_pkg::status_t status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Transmit start then a start bit of at least eight cycles
  sequence tx_go; tx_valid && tx_ready; endsequence
  sequence start_bit; (!txd && tx_drive_en && !tx_ready) [*8]; endsequence

  tx_start_a: assert property (tx_go |=> start_bit)
    else $error("start bit wrong");
  tx_idle_a: assert property (tx_ready |-> txd && !tx_drive_en)
    else $error("idle line driven");
  frame_one_a: assert property (!(frame_good && frame_bad))
    else $error("frame both good and bad");
  link_refuse_a: assert property (cfg_wr_fmt && cfg_from_link |=>
    status.refused && fmt == $past(fmt)) else $error("link format write taken");
  sup_write_a: assert property (cfg_wr_sup |=> sup == $past(cfg_sup) ||
    status.refused && sup == $past(sup)) else $error("supervisor write lost");
  cfg_hold_a: assert property (!cfg_wr_fmt && !cfg_wr_sup |=>
    $stable(fmt) && $stable(sup)) else $error("settings moved");
  act_map_a: assert property ($rose(status.timeout) |-> stop_act ==
    {sup.timeout_action_select == ACT_RAMP1, sup.timeout_action_select == ACT_COAST,
     sup.timeout_action_select == ACT_RAMP2}) else $error("wrong stop action");
  arm_only_a: assert property ($rose(status.timeout) |->
    $past(sup.timeout_detect_time) != 8'h00) else $error("time-out while disabled");
  stop_hold_a: assert property (stop_act != 3'h0 |-> !drive_run)
    else $error("running while stopped");
  good_clear_a: assert property (frame_good |=> !status.timeout)
    else $error("frame did not clear time-out");
endmodule // serial_node_sva

bind serial_node_comm_timeout serial_node_sva u_sva (
  .clk(clk), .rst(rst), .txd(txd), .tx_drive_en(tx_drive_en), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .frame_good(frame_good), .frame_bad(frame_bad),
  .cfg_wr_fmt(cfg_wr_fmt), .cfg_wr_sup(cfg_wr_sup), .cfg_from_link(cfg_from_link),
  .cfg_sup(cfg_sup), .fmt(fmt), .sup(sup), .drive_run(drive_run),
  .stop_act(stop_act), .status(status));

/* File: dv/serial_node_comm_timeout_tb_top.sv */
// Purpose: Self-checking bench of the serial node front end
// Assumes: Short bit base and tenth-second count parameters
// Notes:   Inputs change on the falling edge
module serial_node_comm_timeout_tb_top;
  import serial_node_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BB = 8;
  localparam int TC = 20;
  logic       clk, rst, rxd, txd, tx_drive_en, tx_valid, tx_ready, rx_valid, rf;
  logic       frame_good, frame_bad, cfg_wr_fmt, cfg_wr_sup, cfg_from_link;
  logic       reset_key, run_cmd, drive_run;
  logic [7:0] tx_data, rx_data;
  fmt_t       cfg_fmt, fmt, cur;
  sup_t       cfg_sup, sup;
  stop_t      stop_act;
  status_t    status;
  int         n_errors, n_checks, ng, nb, nv, ne, n, len, np;
  fmt_t       ft [3] = '{'{8'h05, RATE_38400, 1'b0, PAR_EVEN, 1'b0},
                         '{8'h05, RATE_38400, STOP_TWO, PAR_ODD, WIDTH_7},
                         '{8'h05, RATE_38400, 1'b0, PAR_NONE, 1'b0}};

  serial_node_comm_timeout #(.BIT_BASE(13'(BB)), .TENTH_CNT(21'(TC))) dut (
    .clk(clk), .rst(rst), .rxd(rxd), .txd(txd), .tx_drive_en(tx_drive_en),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .frame_good(frame_good), .frame_bad(frame_bad),
    .cfg_wr_fmt(cfg_wr_fmt), .cfg_wr_sup(cfg_wr_sup), .cfg_from_link(cfg_from_link),
    .cfg_fmt(cfg_fmt), .cfg_sup(cfg_sup), .fmt(fmt), .sup(sup), .reset_key(reset_key),
    .run_cmd(run_cmd), .drive_run(drive_run), .stop_act(stop_act), .status(status));
  link_master #(.BIT(BB)) host (.clk(clk), .txd(txd), .cfg(cur), .rxd(rxd));

  // Clock and frame pulse tallies
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    ng <= ng + frame_good;
    nb <= nb + frame_bad;
    nv <= nv + rx_valid;
    ne <= ne + status.char_error;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Settings write, refusal pulse caught in rf
  task automatic wr(input logic wf, ws, lk, input fmt_t f, input sup_t s);
    cfg_fmt = f; cfg_sup = s; cfg_from_link = lk; cfg_wr_fmt = wf; cfg_wr_sup = ws;
    cyc(1);
    rf = status.refused;
    cfg_wr_fmt = 1'b0; cfg_wr_sup = 1'b0; cfg_from_link = 1'b0;
    cyc(1);
  endtask
  // Sends one character and times it until ready returns
  task automatic txm(input logic [7:0] d, input logic [7:0] ed, input logic ep);
    logic [7:0] g;
    logic       gp;
    fork
      host.grab(g, gp);
      begin
        tx_data = d; tx_valid = 1'b1;
        cyc(1);
        tx_valid = 1'b0;
        for (n = 0; !tx_ready && n < 5000; n++) cyc(1);
      end
    join
    check(n >= len - 1 && n <= len + 1, 1);
    check(g, ed);
    check(gp, ep);
  endtask
  // Two character frame, then the frame end gap
  task automatic fr(input logic [7:0] a, input logic bad, input int eg, input int eb);
    int g0, b0, v0, e0;
    g0 = ng; b0 = nb; v0 = nv; e0 = ne;
    host.send(a, 1'b0);
    host.send(8'h3C, bad);
    cyc(40 * (BB << (3 - cur.bit_rate_select)));
    check(ng - g0, eg);
    check(nb - b0, eb);
    check(nv - v0, 2 * (eg + eb));
    check(ne - e0, bad);
  endtask

  initial begin
    cyc(100000);
    n_errors++;
    results();
  end
  initial begin
    n_errors = 0; n_checks = 0; ng = 0; nb = 0; nv = 0; ne = 0;
    rst = 1'b1; tx_valid = 1'b0;
    tx_data = 8'h00; cfg_wr_fmt = 1'b0; cfg_wr_sup = 1'b0; cfg_from_link = 1'b0;
    cfg_fmt = '0; cfg_sup = '0; reset_key = 1'b0; run_cmd = 1'b0;
    cur = '{RST_NODE, RST_RATE, 1'b0, PAR_NONE, 1'b0};
    cyc(12);
    rst = 1'b0;
    cyc(1);
    check(fmt, cur);
    check(sup, 10'h000);
    check({txd, tx_ready, tx_drive_en}, 3'b110);
    $display("test reset done");
    // Link write, node zero and node 255 all refused
    for (int i = 0; i < 3; i++) begin
      wr(1'b1, 1'b0, i == 0, '{i == 1 ? 8'h00 : i == 2 ? 8'hFF : 8'h05,
         RATE_38400, 1'b0, PAR_EVEN, 1'b0}, '0);
      check(rf, 1);
      check(fmt, cur);
    end
    $display("test refused writes done");
    // Every bit rate code timed on a ten bit character
    for (int r = 0; r < 4; r++) begin
      cur = '{8'h05, 2'(r), 1'b0, PAR_NONE, 1'b0};
      wr(1'b1, 1'b0, 1'b0, cur, '0);
      check(fmt, cur);
      len = (BB << (3 - r)) * 10;
      txm(8'h5A, 8'h5A, 1'b0);
    end
    $display("test bit rates done");
    // Stop, parity and width codes on both directions
    for (int i = 0; i < 3; i++) begin
      cur = ft[i];
      wr(1'b1, 1'b0, 1'b0, cur, '0);
      np = cur.parity_select != PAR_NONE;
      len = BB * (2 + (cur.char_width_select ? 7 : 8) + np + cur.stop_bit_select);
      txm(8'hC3, cur.char_width_select ? 8'h43 : 8'hC3,
          np && ((^(8'hC3 & (cur.char_width_select ? 8'h7F : 8'hFF))) ^ (i == 1)));
      fr(8'h05, 1'b0, 1, 0);
      check(rx_data, 8'h3C);
      fr(8'h00, 1'b0, 1, 0);
      fr(8'h07, 1'b0, 0, 0);
      if (np) fr(8'h05, 1'b1, 0, 1);
    end
    $display("test formats done");
    // Supervisor write during traffic refused
    fork
      host.send(8'h05, 1'b0);
      begin
        cyc(20);
        check(status.busy, 1);
        wr(1'b0, 1'b1, 1'b0, '0, '{ACT_COAST, 8'h10});
        check(rf, 1);
        check(sup, 10'h000);
      end
    join
    cyc(400);
    $display("test busy refusal done");
    // Each time-out action, cleared by key or frame, restart needs run edge
    run_cmd = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(1'b0, 1'b1, 1'b0, '0, '{2'(k), 8'h00});
      cyc(3);
      check(drive_run, 1);
      wr(1'b0, 1'b1, 1'b0, '0, '{2'(k), 8'h04});
      for (n = 0; !status.timeout && n < 200; n++) cyc(1);
      check(n >= 4 * TC - 4 && n <= 4 * TC + 2, 1);
      check(stop_act, {k == 0, k == 1, k == 2});
      check(drive_run, k == 3);
      if (k[0]) fr(8'h05, 1'b0, 1, 0);
      else begin
        reset_key = 1'b1;
        cyc(1);
        reset_key = 1'b0;
        cyc(1);
      end
      check(status.timeout, 0);
      check(drive_run, k == 3);
      wr(1'b0, 1'b1, 1'b0, '0, '{2'(k), 8'h00});
      run_cmd = 1'b0;
      cyc(2);
      run_cmd = 1'b1;
      cyc(3);
      check(drive_run, 1);
      check(stop_act, 3'h0);
    end
    cyc(200);
    check(status.timeout, 0);
    $display("test time-out done");
    results();
  end
endmodule // serial_node_comm_timeout_tb_top
